// file: hdl/etxd_ctrl.sv
/*
 * transmit buffered dma control: apb registers, descriptor walk, burst
 * fetch into the transmit buffer, drain into the mac transmit fifo.
 * assumes: memory port and mac port are logic on pclk; descriptor is three
 * words: buffer address, owner bit 31 plus word count [11:0], next pointer.
 */
`timescale 1ns/10ps
`include "etxd_defs.svh"

// Overview of operation
// - run bit enables fetching of frames
// - buffer keeps draining after run cleared
// - null next pointer clears run bit
// - unowned descriptor with stop policy clears run
// - soft reset bit restores reset state everywhere but in the buffer memory
// - burst code maps to 1..32 words
// - skip policy moves to next descriptor
// - stop policy stops, raises not owned interrupt
// - control packet sent interrupt when enabled
// - null list interrupt when enabled
// - not owned interrupt needs enable and stop
// - start level delays drain, frame end immediate
module etxd_ctrl (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system memory read port
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  output logic      [5:0]  mem_len,
  input  wire logic        mem_gnt,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  // mac transmit fifo port
  input  wire logic        mac_tx_en,
  input  wire logic        mac_ready,
  output logic             mac_valid,
  output logic      [31:0] mac_data,
  output logic             mac_last,
  input  wire logic        mac_ctrl_done,
  // interrupt pulses
  output logic             irq_null_list,
  output logic             irq_not_owned,
  output logic             irq_ctrl_sent,
  output logic             irq_buf_empty
);
  etxd_pkg::etxd_regs_s r;       // current state
  etxd_pkg::etxd_regs_s nxt_r;   // next state
  logic [31:0] ctrl_rd;          // control register read view
  logic [6:0]  cnt;              // words held in buffer
  logic [6:0]  free;             // free buffer words
  logic [2:0]  msl_cl;           // start level clamped to 4/8
  logic [6:0]  lvl;              // start level in words
  logic        go;               // drain allowed for current frame
  logic        accept;           // mac takes a word this cycle
  logic        pop;              // buffer read this cycle
  logic        push;             // buffer write this cycle
  logic [32:0] q;                // buffer read register
  logic [5:0]  bw;               // burst words from code
  logic [5:0]  dlen;             // next data burst length
  logic        room;             // buffer can take the burst
  logic        setup;            // apb setup phase
  logic        wr_acc;           // apb write access
  logic        hit;              // address decodes
  logic        wr_ctrl;          // write to control register

  ////////////////////////////////////////////////////////////////////////////
  // burst code decode
  function automatic logic [5:0] burst_words(input logic [4:0] code);
    logic [5:0] sum;
    sum = {1'b0, code} + 6'h01;
    if (code <= 5'h02) begin
      burst_words = 6'h01;
    end else if (code == 5'h1F) begin
      burst_words = `ETXD_BURST_MAX;
    end else begin
      burst_words = {sum[5:2], 2'b00};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational helpers
  assign ctrl_rd = {16'h0000, 1'b0, r.run, r.msl, r.empty_ie, r.noie,
                    r.nlie, r.ccpie, 1'b0, r.stsk, r.burst};
  assign cnt    = r.wr_ptr - r.rd_ptr;
  assign free   = `ETXD_BUF_DEPTH - cnt;
  assign msl_cl = (r.msl > `ETXD_MSL_MAX) ? `ETXD_MSL_MAX : r.msl;
  assign lvl    = {1'b0, msl_cl, 3'b000};
  // frame end in buffer forwards at once
  assign go     = r.started || (r.eof_cnt != 7'h00) || (cnt >= lvl);
  // drain does not look at run
  assign accept = r.out_valid && mac_ready && mac_tx_en;
  assign pop    = (cnt != 7'h00) && go &&
                  (!r.out_valid || (accept && !q[32]));
  assign push   = mem_rvalid && (r.state == etxd_pkg::ST_DATA_RX);
  assign bw     = burst_words(r.burst);
  assign dlen   = (r.remain < {6'h00, bw}) ? r.remain[5:0] : bw;
  assign room   = free >= {1'b0, r.req_len};
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign hit    = (paddr == `ETXD_CTRL_OFS) || (paddr == `ETXD_PTR_OFS) ||
                  (paddr == `ETXD_STAT_OFS);
  assign wr_ctrl = wr_acc && (paddr == `ETXD_CTRL_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_r = r;
    nxt_r.irq_null  = 1'b0;
    nxt_r.irq_nown  = 1'b0;
    nxt_r.irq_ctrl  = mac_ctrl_done && r.ccpie;
    nxt_r.irq_empty = accept && (cnt == 7'h00) && !pop && r.empty_ie;
    // buffer write side
    if (push) begin
      nxt_r.wr_ptr = r.wr_ptr + 7'h01;
      if (r.remain == 12'h001) begin
        nxt_r.eof_cnt = r.eof_cnt + 7'h01;
      end
    end
    // buffer read side and output stage
    if (pop) begin
      nxt_r.rd_ptr  = r.rd_ptr + 7'h01;
      nxt_r.started = 1'b1;
    end
    if (accept && q[32]) begin
      // last word left: next frame waits for its start level again
      nxt_r.started = 1'b0;
      nxt_r.eof_cnt = nxt_r.eof_cnt - 7'h01;
    end
    nxt_r.out_valid = pop || (r.out_valid && !accept);
    // descriptor walk
    case (r.state)
      etxd_pkg::ST_IDLE: begin
        if (r.run && (r.ptr == `ETXD_NULL_PTR)) begin
          nxt_r.run      = 1'b0;
          nxt_r.irq_null = r.nlie;
        end else if (r.run) begin
          // pointer was loaded by software before run, or from the next pointer in ST_NEXT
          nxt_r.req_addr = r.ptr;
          nxt_r.widx     = 2'h0;
          nxt_r.state    = etxd_pkg::ST_DESC_REQ;
        end
      end
      etxd_pkg::ST_DESC_REQ: begin
        if (mem_gnt) begin
          nxt_r.state = etxd_pkg::ST_DESC_RX;
        end
      end
      etxd_pkg::ST_DESC_RX: begin
        if (mem_rvalid) begin
          nxt_r.widx = r.widx + 2'h1;
          if (r.widx == 2'h0) begin
            nxt_r.buf_addr = mem_rdata;
          end else if (r.widx == 2'h1) begin
            nxt_r.owner  = mem_rdata[`ETXD_OWN_BIT];
            nxt_r.remain = mem_rdata[11:0];
          end else begin
            nxt_r.nxt_desc = mem_rdata;
            nxt_r.state    = etxd_pkg::ST_CHECK;
          end
        end
      end
      etxd_pkg::ST_CHECK: begin
        if (!r.owner && r.stsk) begin
          nxt_r.run      = 1'b0;
          nxt_r.irq_nown = r.noie;
          nxt_r.state    = etxd_pkg::ST_IDLE;
        end else if (!r.owner || (r.remain == 12'h000)) begin
          nxt_r.state = etxd_pkg::ST_NEXT;
        end else begin
          nxt_r.req_addr = r.buf_addr;
          nxt_r.req_len  = dlen;
          nxt_r.state    = etxd_pkg::ST_DATA_REQ;
        end
      end
      etxd_pkg::ST_DATA_REQ: begin
        if (room && mem_gnt) begin
          nxt_r.beats = r.req_len;
          nxt_r.state = etxd_pkg::ST_DATA_RX;
        end
      end
      etxd_pkg::ST_DATA_RX: begin
        if (mem_rvalid) begin
          nxt_r.remain = r.remain - 12'h001;
          nxt_r.beats  = r.beats - 6'h01;
          if (r.remain == 12'h001) begin
            nxt_r.state = etxd_pkg::ST_NEXT;
          end else if (r.beats == 6'h01) begin
            nxt_r.req_addr = r.req_addr + {24'h000000, r.req_len, 2'b00};
            nxt_r.req_len  = dlen - 6'h00;
            nxt_r.state    = etxd_pkg::ST_DATA_REQ;
          end
        end
      end
      etxd_pkg::ST_NEXT: begin
        // idle decides on run and on a null pointer
        nxt_r.ptr   = r.nxt_desc;
        nxt_r.state = etxd_pkg::ST_IDLE;
      end
      default: begin
        nxt_r.state = etxd_pkg::ST_IDLE;
      end
    endcase
    // fix next data burst length on the last word of this burst
    if ((r.state == etxd_pkg::ST_DATA_RX) && mem_rvalid &&
        (r.beats == 6'h01) && (r.remain != 12'h001)) begin
      nxt_r.req_len = ((r.remain - 12'h001) < {6'h00, bw}) ?
                      6'(r.remain - 12'h001) : bw;
    end
    // register writes, a software set wins over the hardware clear
    if (wr_acc && (paddr == `ETXD_PTR_OFS)) begin
      nxt_r.ptr = pwdata;
    end
    if (wr_ctrl) begin
      nxt_r.burst    = pwdata[`ETXD_BURST_LSB +: 5];
      nxt_r.stsk     = pwdata[`ETXD_STSK_BIT];
      nxt_r.ccpie    = pwdata[`ETXD_CCPIE_BIT];
      nxt_r.nlie     = pwdata[`ETXD_NLIE_BIT];
      nxt_r.noie     = pwdata[`ETXD_NOIE_BIT];
      nxt_r.empty_ie = pwdata[`ETXD_EMPTY_BIT];
      nxt_r.msl      = pwdata[`ETXD_MSL_LSB +: 3];
      nxt_r.run      = pwdata[`ETXD_RUN_BIT];
    end
    // read data captured in the setup phase
    if (setup) begin
      nxt_r.rdata = (paddr == `ETXD_CTRL_OFS) ? ctrl_rd :
                    (paddr == `ETXD_PTR_OFS)  ? r.ptr :
                    (paddr == `ETXD_STAT_OFS) ?
                    {15'h0000, r.run, r.out_valid, r.state, r.started, cnt} :
                    32'h00000000;
    end
    // soft reset returns everything but the buffer memory to reset state
    if (wr_ctrl && pwdata[`ETXD_SRST_BIT]) begin
      nxt_r       = '0;
      nxt_r.state = etxd_pkg::ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.state <= etxd_pkg::ST_IDLE;
    end else begin
      r <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer
  etxd_buf_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (push),
    .waddr   (r.wr_ptr[`ETXD_BUF_AW-1:0]),
    .wdata   ({r.remain == 12'h001, mem_rdata}),
    .re      (pop),
    .raddr   (r.rd_ptr[`ETXD_BUF_AW-1:0]),
    .q       (q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata        = r.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !hit;
  assign mem_req       = (r.state == etxd_pkg::ST_DESC_REQ) ||
                         ((r.state == etxd_pkg::ST_DATA_REQ) && room);
  assign mem_addr      = r.req_addr;
  assign mem_len       = (r.state == etxd_pkg::ST_DESC_REQ) ? 6'h03 :
                         r.req_len;
  assign mac_valid     = r.out_valid;
  assign mac_data      = q[31:0];
  assign mac_last      = q[32];
  assign irq_null_list = r.irq_null;
  assign irq_not_owned = r.irq_nown;
  assign irq_ctrl_sent = r.irq_ctrl;
  assign irq_buf_empty = r.irq_empty;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unowned_check;
    (r.state == etxd_pkg::ST_CHECK) && !r.owner && !wr_ctrl;
  endsequence

  a_idle_no_fetch: assert property (
    (r.state == etxd_pkg::ST_IDLE) && !r.run && !wr_ctrl |=> !mem_req[*2])
    else $error("fetch started without run");
  a_drain_without_run: assert property (
    !r.out_valid && (cnt != 7'h00) && go && !wr_ctrl |=> mac_valid)
    else $error("buffer did not drain");
  a_null_stop: assert property (
    (r.state == etxd_pkg::ST_IDLE) && r.run && (r.ptr == 32'h0) && !wr_ctrl
    |=> !r.run && (r.state == etxd_pkg::ST_IDLE))
    else $error("null pointer did not clear run");
  a_unowned_stop: assert property (
    s_unowned_check ##0 r.stsk |=> !r.run ##1 !mem_req)
    else $error("unowned descriptor did not stop");
  a_soft_reset: assert property (
    wr_ctrl && pwdata[15] |=> (ctrl_rd == 32'h0) &&
    (r.state == etxd_pkg::ST_IDLE) && (cnt == 7'h00))
    else $error("soft reset incomplete");
  a_burst_map: assert property (
    (r.burst == 5'h1F |-> bw == 6'h20) and (r.burst <= 5'h02 |-> bw == 6'h01)
    and (r.burst == 5'h0B |-> bw == 6'h0C))
    else $error("burst code decode wrong");
  a_unowned_skip: assert property (
    s_unowned_check ##0 !r.stsk |=> (r.state == etxd_pkg::ST_NEXT) ##1
    (r.ptr == $past(r.nxt_desc)))
    else $error("unowned descriptor not skipped");
  a_nown_irq: assert property (
    s_unowned_check ##0 r.stsk |=> irq_not_owned == $past(r.noie))
    else $error("not owned interrupt wrong");
  a_nown_gate: assert property (
    irq_not_owned |-> $past(r.noie && r.stsk))
    else $error("not owned interrupt without enable");
  a_ctrl_irq: assert property (
    mac_ctrl_done && !wr_ctrl |=> irq_ctrl_sent == $past(r.ccpie))
    else $error("control sent interrupt wrong");
  a_null_irq: assert property (
    irq_null_list |-> $past(r.nlie && (r.ptr == 32'h0)))
    else $error("null list interrupt wrong");
  a_start_level: assert property (
    pop && !r.started && (r.eof_cnt == 7'h00) |->
    (cnt >= 7'h20) || (cnt >= {1'b0, r.msl, 3'b000}))
    else $error("drain before start level");
  a_reserved_zero: assert property (
    ctrl_rd[31:15] == 17'h0 && !ctrl_rd[6])
    else $error("reserved control bits not zero");
endmodule

// file: pkg/etxd_defs.svh
/*
 * register offsets, field positions, reset values and buffer sizes of the
 * transmit buffered dma control block.
 * assumes: included by the package and the design files by bare name.
 */
`ifndef ETXD_DEFS_SVH
`define ETXD_DEFS_SVH

// register byte addresses on the apb bus
`define ETXD_CTRL_OFS    16'h9000
`define ETXD_PTR_OFS     16'h9010
`define ETXD_STAT_OFS    16'h9014

// control register field positions
`define ETXD_BURST_LSB   0
`define ETXD_STSK_BIT    5
`define ETXD_CCPIE_BIT   7
`define ETXD_NLIE_BIT    8
`define ETXD_NOIE_BIT    9
`define ETXD_EMPTY_BIT   10
`define ETXD_MSL_LSB     11
`define ETXD_RUN_BIT     14
`define ETXD_SRST_BIT    15
`define ETXD_CTRL_RST    32'h00000000

// transmit buffer geometry
`define ETXD_BUF_DEPTH   7'h40
`define ETXD_BUF_AW      6
`define ETXD_EIGHTH      3'h3
`define ETXD_MSL_MAX     3'h4
`define ETXD_BURST_MAX   6'h20
`define ETXD_OWN_BIT     31
`define ETXD_NULL_PTR    32'h00000000

`endif

// file: pkg/etxd_pkg.sv
/*
 * types of the transmit buffered dma control block: fsm states, state struct.
 * assumes: etxd_defs.svh on the include path.
 */
package etxd_pkg;
  `include "etxd_defs.svh"

  // descriptor walk and data fetch states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_DESC_REQ = 7'h02,
    ST_DESC_RX  = 7'h04,
    ST_CHECK    = 7'h08,
    ST_DATA_REQ = 7'h10,
    ST_DATA_RX  = 7'h20,
    ST_NEXT     = 7'h40
  } etxd_state_e;

  // all state of the control module
  typedef struct packed {
    etxd_state_e state;
    logic [4:0]  burst;
    logic        stsk;
    logic        ccpie;
    logic        nlie;
    logic        noie;
    logic        empty_ie;
    logic [2:0]  msl;
    logic        run;
    logic [31:0] ptr;
    logic [31:0] buf_addr;
    logic [31:0] nxt_desc;
    logic        owner;
    logic [11:0] remain;
    logic [1:0]  widx;
    logic [5:0]  beats;
    logic [31:0] req_addr;
    logic [5:0]  req_len;
    logic [6:0]  wr_ptr;
    logic [6:0]  rd_ptr;
    logic [6:0]  eof_cnt;
    logic        started;
    logic        out_valid;
    logic [31:0] rdata;
    logic        irq_null;
    logic        irq_nown;
    logic        irq_ctrl;
    logic        irq_empty;
  } etxd_regs_s;

  // state of the buffer memory: 64 words plus end of frame bit
  typedef struct packed {
    logic [63:0][32:0] mem;
    logic [32:0]       q;
  } etxd_mem_s;
endpackage

// file: hdl/etxd_buf_mem.sv
/*
 * transmit buffer memory: one write port, one read port, registered read.
 * assumes: pclk domain only; the caller never writes a full buffer.
 */
`timescale 1ns/10ps
`include "etxd_defs.svh"

module etxd_buf_mem (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // write port
  input  wire logic                     we,
  input  wire logic [`ETXD_BUF_AW-1:0]  waddr,
  input  wire logic [32:0]              wdata,
  // read port, data valid one cycle after re
  input  wire logic                     re,
  input  wire logic [`ETXD_BUF_AW-1:0]  raddr,
  output logic      [32:0]              q
);
  etxd_pkg::etxd_mem_s r;     // current state
  etxd_pkg::etxd_mem_s nxt_r; // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: store on write, load read register on read
  always_comb begin
    nxt_r = r;
    if (we) begin
      nxt_r.mem[waddr] = wdata;
    end
    if (re) begin
      nxt_r.q = r.mem[raddr];
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= nxt_r;
    end
  end

  assign q = r.q;
endmodule

// file: verif/etxd_far_model.sv
/*
 * far side model: word memory answering bursts, mac fifo taking words.
 * assumes: all on pclk; the bench preloads mem and reads the queues.
 */
`timescale 1ns/10ps

module etxd_far_model (
  // clock
  input  wire logic        pclk,
  // memory read port
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [5:0]  mem_len,
  output logic             mem_gnt,
  output logic             mem_rvalid,
  output logic      [31:0] mem_rdata,
  // mac fifo port
  input  wire logic        mac_tx_en,
  input  wire logic        stall,
  output logic             mac_ready,
  input  wire logic        mac_valid,
  input  wire logic [31:0] mac_data,
  input  wire logic        mac_last
);
  logic [31:0] mem [64];  // word memory
  logic [5:0]  lens [$];  // burst lengths taken
  logic [31:0] got [$];   // words taken by the mac
  logic        lastq [$]; // end flags taken
  int          n_fed;     // words handed over
  int          fed_first; // n_fed at first mac word
  logic [1:0]  cyc = 2'h0; // mac pacing
  logic        slow;      // alternates prompt and slow bursts
  logic [5:0]  a;         // burst word index

  ////////////////////////////////////////////////////////////////////////
  // memory: grant, then the words in order, a gap in slow bursts
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'hC0DE0000 + 32'(i);
    end
    {mem_gnt, mem_rvalid, slow} = '0;
    mem_rdata = 32'h00000000;
    n_fed = 0;
    forever begin
      @(posedge pclk);
      if (mem_req === 1'b1) begin
        a = mem_addr[7:2];
        lens.push_back(mem_len);
        mem_gnt <= 1'b1;
        @(posedge pclk);
        mem_gnt <= 1'b0;
        for (int k = 0; k < int'(lens[$]); k++) begin
          // idle data line shows a changing pattern
          if (slow && k == 1) begin
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            @(posedge pclk);
          end
          mem_rvalid <= 1'b1;
          mem_rdata  <= mem[a + k[5:0]];
          @(posedge pclk);
          n_fed++;
        end
        mem_rvalid <= 1'b0;
        mem_rdata  <= ~mem_rdata;
        slow = ~slow;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mac fifo: ready three cycles in four unless stalled
  always @(posedge pclk) begin
    cyc       <= cyc + 2'h1;
    mac_ready <= !stall && (cyc != 2'h3);
    if (mac_valid && mac_ready && mac_tx_en) begin
      if (got.size() == 0) fed_first = n_fed;
      got.push_back(mac_data);
      lastq.push_back(mac_last);
    end
  end
endmodule

// file: verif/tb_etxd_ctrl.sv
/*
 * self-checking bench: apb register access, frames, policies, interrupts.
 * assumes: etxd_defs.svh on the include path; far model beside the dut.
 */
`timescale 1ns/10ps
`include "etxd_defs.svh"

module tb_etxd_ctrl;
  localparam logic [15:0] CTRL = `ETXD_CTRL_OFS; // control register
  localparam logic [15:0] PTR  = `ETXD_PTR_OFS;  // descriptor pointer
  localparam logic [31:0] RUN  = 32'h00004000;   // run bit
  logic        pclk, presetn, psel, penable, pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat, mem_addr, mem_rdata, mac_data;
  logic        pready, pslverr, rerr, mem_req, mem_gnt, mem_rvalid;
  logic [5:0]  mem_len;
  logic        mac_tx_en, mac_ready, mac_valid, mac_last, mac_ctrl_done;
  logic        irq_null_list, irq_not_owned, irq_ctrl_sent, irq_buf_empty;
  logic        stall;              // mac stall request
  int          mismatches, n_compared;
  int          n_irq [4];          // pulse counts
  logic [4:0]  code [7] = '{5'h00, 5'h02, 5'h03, 5'h06, 5'h07, 5'h1E, 5'h1F};
  int          blen [7] = '{1, 1, 4, 4, 8, 28, 32};

  etxd_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_len(mem_len),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .mac_tx_en(mac_tx_en), .mac_ready(mac_ready), .mac_valid(mac_valid),
    .mac_data(mac_data), .mac_last(mac_last), .mac_ctrl_done(mac_ctrl_done),
    .irq_null_list(irq_null_list), .irq_not_owned(irq_not_owned),
    .irq_ctrl_sent(irq_ctrl_sent), .irq_buf_empty(irq_buf_empty));
  etxd_far_model mdl (.pclk(pclk), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_len(mem_len), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .mac_tx_en(mac_tx_en), .stall(stall),
    .mac_ready(mac_ready), .mac_valid(mac_valid), .mac_data(mac_data),
    .mac_last(mac_last));

  ////////////////////////////////////////////////////////////////////////
  // clock and interrupt pulse counters
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (irq_null_list === 1'b1) n_irq[0]++;
    if (irq_not_owned === 1'b1) n_irq[1]++;
    if (irq_ctrl_sent === 1'b1) n_irq[2]++;
    if (irq_buf_empty === 1'b1) n_irq[3]++;
  end

  ////////////////////////////////////////////////////////////////////////
  // apb transfer: setup, access until pready, then one idle cycle
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // value compare
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask

  // descriptor: buffer word, owner, word count, next descriptor word
  task automatic desc(input int i, input int b, input logic own,
                      input int cnt, input int nx);
    mdl.mem[i]     = 32'(b * 4);
    mdl.mem[i + 1] = {own, 19'h00000, 12'(cnt)};
    mdl.mem[i + 2] = 32'(nx * 4);
  endtask

  // forget what the far side and the counters saw
  task automatic clr();
    mdl.got.delete();
    mdl.lastq.delete();
    mdl.lens.delete();
    mdl.n_fed = 0;
    n_irq = '{0, 0, 0, 0};
  endtask

  // poll until the run bit reads clear, bounded
  task automatic wait_idle();
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, CTRL, 32'h00000000);
      if (rdat[`ETXD_RUN_BIT] === 1'b0) break;
    end
  endtask

  // wait for n words at the mac, bounded
  task automatic wait_words(input int n);
    for (int i = 0; i < 2000 && mdl.got.size() < n; i++) @(posedge pclk);
    // let the pulses that follow the last word reach the counters
    repeat (2) @(posedge pclk);
  endtask

  // frame contents and end flag at the mac
  task automatic chk_frame(input int b, input int n);
    chk(32'(mdl.got.size()), 32'(n), "word count");
    foreach (mdl.got[k]) begin
      chk(mdl.got[k], 32'hC0DE0000 + 32'(b + k), "word");
      chk(32'(mdl.lastq[k]), 32'(k == n - 1), "end flag");
    end
  endtask

  // closing report
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, stall, mac_ctrl_done} = '0;
    {paddr, pwdata} = '0;
    mac_tx_en = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // register reset value, reserved bits, soft reset, unmapped place
    apb(1'b0, CTRL, 32'h0);
    chk(rdat, `ETXD_CTRL_RST, "ctrl reset");
    apb(1'b1, CTRL, 32'hFFFF3FFF);
    apb(1'b0, CTRL, 32'h0);
    chk(rdat, 32'h00003FBF, "ctrl fields");
    apb(1'b1, PTR, 32'h00000040);
    apb(1'b1, CTRL, 32'h00008000);
    apb(1'b0, CTRL, 32'h0);
    chk(rdat, 32'h0, "soft reset ctrl");
    apb(1'b0, PTR, 32'h0);
    chk(rdat, 32'h0, "soft reset ptr");
    apb(1'b0, 16'h9020, 32'h0);
    chk(32'(rerr), 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
    // null pointer with the interrupt off and on
    for (int ie = 0; ie < 2; ie++) begin
      clr();
      apb(1'b1, PTR, 32'h0);
      apb(1'b1, CTRL, RUN | 32'(ie) << `ETXD_NLIE_BIT);
      wait_idle();
      chk(32'(rdat[14]), 32'h0, "run after null");
      chk(32'(n_irq[0] > 0), 32'(ie), "null irq");
    end
    // one 40 word frame per burst code, last with start level 4/8
    for (int c = 0; c < 7; c++) begin
      clr();
      desc(4, 16, 1'b1, 40, 0);
      apb(1'b1, PTR, 32'h10);
      apb(1'b1, CTRL, RUN | 32'(code[c]) | (c == 6 ? 32'h2400 : 32'h0));
      wait_idle();
      wait_words(40);
      chk(32'(rdat[14]), 32'h0, "run after frame");
      chk(32'(mdl.lens[1]), 32'(blen[c]), "burst len");
      chk_frame(16, 40);
    end
    chk(32'(mdl.fed_first >= 35), 32'h1, "start level");
    chk(32'(n_irq[3]), 32'h1, "empty irq");
    // drain goes on after run is cleared, held while the mac is off
    clr();
    stall <= 1'b1;
    desc(4, 16, 1'b1, 40, 0);
    apb(1'b1, PTR, 32'h10);
    apb(1'b1, CTRL, RUN | 32'h1F);
    for (int i = 0; i < 800 && mdl.n_fed < 43; i++) @(posedge pclk);
    apb(1'b1, CTRL, 32'h1F);
    mac_tx_en <= 1'b0;
    stall     <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(32'(mdl.got.size()), 32'h0, "held while tx off");
    mac_tx_en <= 1'b1;
    wait_words(40);
    chk_frame(16, 40);
    // unowned descriptor: skip, stop quiet, stop with interrupt
    for (int i = 0; i < 3; i++) begin
      clr();
      desc(4, 16, 1'b0, 4, 8);
      desc(8, 56, 1'b1, 4, 0);
      apb(1'b1, PTR, 32'h10);
      apb(1'b1, CTRL, RUN | 32'(i > 0) << 5 | 32'(i == 2) << 9);
      wait_idle();
      wait_words(i > 0 ? 0 : 4);
      repeat (10) @(posedge pclk);
      chk(32'(rdat[14]), 32'h0, "run after stop");
      chk(32'(mdl.got.size()), i > 0 ? 0 : 4, "skip words");
      if (i == 0) chk(mdl.got[0], 32'hC0DE0038, "skip data");
      chk(32'(n_irq[1]), 32'(i == 2), "not owned irq");
    end
    // control packet sent, interrupt off and on; no fetch with run low
    for (int ie = 0; ie < 2; ie++) begin
      clr();
      apb(1'b1, CTRL, 32'(ie) << 7);
      mac_ctrl_done <= 1'b1;
      @(posedge pclk);
      mac_ctrl_done <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(n_irq[2]), 32'(ie), "ctrl sent irq");
      chk(32'(mdl.lens.size()), 32'h0, "no fetch");
    end
    give_verdict();
  end
endmodule
